/* hdl/srq_ack_pkg.sv */
/*
 service request / acknowledge chain package: timing counts, encodings.
 assumes a 25 MHz system clock; nothing else.
*/
package srq_ack_pkg;
  localparam int unsigned SYS_CLK_HZ = 25000000;
  // hold-off after end-of-service, in clock periods
  localparam int unsigned EOS_HOLDOFF_CLKS = 2;
  localparam logic [1:0] EOS_HOLDOFF_CNT = 2'(EOS_HOLDOFF_CLKS);
  // vector returned on an unclaimed acknowledge with chaining off
  localparam logic [7:0] INVALID_VECTOR = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [7:0] VECTOR_RST = 8'h00;
  // class index
  localparam int unsigned CLS_MODEM = 0;
  localparam int unsigned CLS_TX = 1;
  localparam int unsigned CLS_RX = 2;
  localparam int unsigned NUM_CLS = 3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01,
    ST_DONE = 2'b11
  } ack_state_t;
endpackage

/* hdl/service_request_ack_chain.sv */
/*
 service request signalling and acknowledge matching / daisy chaining.
 assumes the host decodes its acknowledge level, never overlaps chip select
 with acknowledge-in, and keeps the address stable before acknowledge-in.
*/
`timescale 1ns/100ps
module service_request_ack_chain #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // internal request sources, one per class (modem, tx, rx)
  input wire logic [2:0] i_req_pending,
  input wire logic [7:0] i_modem_vector,
  input wire logic [7:0] i_tx_vector,
  input wire logic [7:0] i_rx_vector,
  // configuration
  input wire logic [ADDR_W-1:0] i_modem_match_reg,
  input wire logic [ADDR_W-1:0] i_tx_match_reg,
  input wire logic [ADDR_W-1:0] i_rx_match_reg,
  input wire logic i_chain_en,
  input wire logic i_end_of_service_wr,
  // host pins
  input wire logic i_chain_ack_in_n,
  input wire logic i_data_strobe_n,
  input wire logic [ADDR_W-1:0] i_addr,
  // outputs
  output logic o_modem_service_req_n,
  output logic o_tx_service_req_n,
  output logic o_rx_service_req_n,
  output logic [2:0] o_request_status_reg,
  output logic o_chain_ack_out_n,
  output logic o_transfer_ack_n,
  output logic [7:0] o_data,
  output logic o_data_oe_n
);
  // pin synchronisers
  logic [1:0] ack_sync_r;
  logic [1:0] ds_sync_r;
  logic [ADDR_W-1:0] addr_s1_r;
  logic [ADDR_W-1:0] addr_s2_r;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_sync_r <= 2'b11;
      ds_sync_r <= 2'b11;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
    end else begin
      ack_sync_r <= {ack_sync_r[0], i_chain_ack_in_n};
      ds_sync_r <= {ds_sync_r[0], i_data_strobe_n};
      addr_s1_r <= i_addr;
      addr_s2_r <= addr_s1_r;
    end
  end
  wire ack_active = !ack_sync_r[1] && !ds_sync_r[1];

  // class match decode
  wire [2:0] hit = {addr_s2_r == i_rx_match_reg,
                    addr_s2_r == i_tx_match_reg,
                    addr_s2_r == i_modem_match_reg};
  wire any_hit = |hit;
  // requests that are raised and not masked by service in progress
  logic [2:0] req_out_r;
  logic [2:0] in_service_r;
  logic [1:0] holdoff_r;
  wire [2:0] pend_hit = hit & req_out_r;
  wire claim = |pend_hit;
  wire [7:0] sel_vector = pend_hit[srq_ack_pkg::CLS_MODEM] ? i_modem_vector :
                          pend_hit[srq_ack_pkg::CLS_TX] ? i_tx_vector : i_rx_vector;

  srq_ack_pkg::ack_state_t state_r;
  srq_ack_pkg::ack_state_t state_nxt;
  logic [2:0] ack_cls_r;
  logic [7:0] data_r;
  logic xfer_ack_r;
  logic fwd_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      srq_ack_pkg::ST_IDLE: begin
        if (ack_active) begin
          state_nxt = srq_ack_pkg::ST_ACK;
        end
      end
      srq_ack_pkg::ST_ACK: begin
        if (!ack_active) begin
          state_nxt = srq_ack_pkg::ST_DONE;
        end
      end
      srq_ack_pkg::ST_DONE: state_nxt = srq_ack_pkg::ST_IDLE;
      default: state_nxt = srq_ack_pkg::ST_IDLE;
    endcase
  end

  wire start_ack = (state_r == srq_ack_pkg::ST_IDLE) && ack_active;
  wire end_ack = (state_r == srq_ack_pkg::ST_DONE);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= srq_ack_pkg::ST_IDLE;
      ack_cls_r <= 3'h0;
      data_r <= srq_ack_pkg::VECTOR_RST;
      xfer_ack_r <= 1'b0;
      fwd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start_ack) begin
        // first pending class wins; one hot
        ack_cls_r <= pend_hit & ~(pend_hit - 3'h1) ;
        if (claim) begin
          data_r <= sel_vector;
          xfer_ack_r <= 1'b1;
          fwd_r <= 1'b0;
        end else if (!i_chain_en) begin
          data_r <= srq_ack_pkg::INVALID_VECTOR;
          xfer_ack_r <= 1'b1;
          fwd_r <= 1'b0;
        end else begin
          // forward only on a match; no match leaves the cycle hanging
          data_r <= srq_ack_pkg::INVALID_VECTOR;
          xfer_ack_r <= 1'b0;
          fwd_r <= any_hit;
        end
      end else if (state_nxt == srq_ack_pkg::ST_DONE) begin
        xfer_ack_r <= 1'b0;
        fwd_r <= 1'b0;
      end
    end
  end

  // request outputs: dropped at acknowledge end, reopened after eos hold-off unless the eos write lands in the acknowledge end cycle
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      in_service_r <= 3'h0;
      holdoff_r <= 2'h0;
      req_out_r <= 3'h0;
    end else begin
      if (end_ack) begin
        in_service_r <= in_service_r | ack_cls_r;
      end else if (i_end_of_service_wr) begin
        in_service_r <= 3'h0;
      end
      if (i_end_of_service_wr) begin
        holdoff_r <= srq_ack_pkg::EOS_HOLDOFF_CNT;
      end else if (holdoff_r != 2'h0) begin
        holdoff_r <= holdoff_r - 2'h1;
      end
      if (i_end_of_service_wr || holdoff_r != 2'h0) begin
        req_out_r <= 3'h0;
      end else begin
        req_out_r <= i_req_pending & ~in_service_r & ~(end_ack ? ack_cls_r : 3'h0);
      end
    end
  end

  // outputs change on the clock; host must still synchronise them
  assign o_modem_service_req_n = !req_out_r[srq_ack_pkg::CLS_MODEM];
  assign o_tx_service_req_n = !req_out_r[srq_ack_pkg::CLS_TX];
  assign o_rx_service_req_n = !req_out_r[srq_ack_pkg::CLS_RX];
  assign o_request_status_reg = req_out_r;
  assign o_chain_ack_out_n = !fwd_r;
  assign o_transfer_ack_n = !xfer_ack_r;
  assign o_data = data_r;
  assign o_data_oe_n = !xfer_ack_r;

  AST_EOS_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_end_of_service_wr |=> (req_out_r == 3'h0) [*2])
    else $error("status bits not held clear after end of service");
  AST_NO_FWD_NOMATCH: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    start_ack && !any_hit |=> o_chain_ack_out_n)
    else $error("acknowledge forwarded without a match");
  AST_FWD_MATCH: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    start_ack && !claim && any_hit && i_chain_en |=> !o_chain_ack_out_n && o_transfer_ack_n)
    else $error("matched unclaimed acknowledge not forwarded");
  AST_NOMATCH_HANG: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    start_ack && !any_hit && i_chain_en |=> o_transfer_ack_n)
    else $error("unmatched acknowledge answered");
  AST_ZERO_VEC: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    start_ack && !claim && !i_chain_en |=> !o_transfer_ack_n && o_data == 8'h00)
    else $error("invalid acknowledge vector not zero");
  AST_CLAIM: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    start_ack && claim |=> !o_transfer_ack_n && o_data == $past(sel_vector))
    else $error("claimed acknowledge not answered with vector");
  AST_NEGATE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    end_ack && ack_cls_r[0] |=> o_modem_service_req_n)
    else $error("modem request not negated after acknowledge");
  AST_NEGATE_TX: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    end_ack && ack_cls_r[srq_ack_pkg::CLS_TX] |=> o_tx_service_req_n)
    else $error("tx request not negated after acknowledge");
  AST_NEGATE_RX: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    end_ack && ack_cls_r[srq_ack_pkg::CLS_RX] |=> o_rx_service_req_n)
    else $error("rx request not negated after acknowledge");
  // compared against the raw match register, not the shared hit decode
  AST_MATCH: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    start_ack && addr_s2_r == i_modem_match_reg && req_out_r[srq_ack_pkg::CLS_MODEM]
    |=> !o_transfer_ack_n && o_data == $past(i_modem_vector))
    else $error("matched modem acknowledge not answered with its vector");
  AST_NOMATCH_FLOAT: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    start_ack && !any_hit && i_chain_en |=> o_data_oe_n)
    else $error("data bus driven on unmatched acknowledge");
  AST_END_RELEASE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    end_ack |-> o_transfer_ack_n && o_chain_ack_out_n)
    else $error("answer still standing after acknowledge release");
endmodule

/* testbench/host_ack_model.sv */
/*
 host side model: acknowledge decode, strobe and bus timeout.
 assumes the bench calls ack_cycle just after a clock edge.
*/
`timescale 1ns/100ps
module host_ack_model (
  // clock
  input wire logic i_sys_clk,
  // device answers
  input wire logic i_transfer_ack_n,
  input wire logic i_chain_ack_out_n,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe_n,
  // acknowledge pins
  output logic o_ack_in_n,
  output logic o_strobe_n,
  output logic [7:0] o_addr
);
  initial begin
    o_ack_in_n = 1'b1;
    o_strobe_n = 1'b1;
    o_addr = 8'hff;
  end
  // the bus timeout ends a cycle nobody answers
  task automatic ack_cycle(input logic [7:0] code, output logic ta_n, output logic ao_n,
      output logic [7:0] d);
    int n;
    @(posedge i_sys_clk);
    #1 o_addr = code; // address settles first
    @(posedge i_sys_clk);
    #1 o_ack_in_n = 1'b0; // clean level decode, no select overlap
    o_strobe_n = 1'b0;
    n = 0;
    while (i_transfer_ack_n === 1'b1 && i_chain_ack_out_n === 1'b1 && n < 8) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    ta_n = i_transfer_ack_n;
    ao_n = i_chain_ack_out_n; // only device levels acked, so no glue bypass
    d = i_data_oe_n ? 8'hff : i_data; // floating bus reads ff
    o_ack_in_n = 1'b1;
    o_strobe_n = 1'b1;
    o_addr = ~code;
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask
endmodule

/* testbench/testbench.sv */
/*
 self-checking bench for the request and acknowledge chain.
 assumes host_ack_model drives the acknowledge pins.
*/
`timescale 1ns/100ps
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [2:0] pend = 3'b000;
  logic chain_en = 1'b1;
  logic eos_wr = 1'b0;
  logic [7:0] vec [3] = '{8'h41, 8'h42, 8'h43};
  logic [7:0] mat [3] = '{8'h81, 8'h82, 8'h83};
  logic ack_in_n, strobe_n, ta_n, ao_n, oe_n, modem_service_req_n_n, tx_service_req_n_n, rx_service_req_n_n, t_ta, t_ao;
  logic [7:0] addr, data, t_d;
  logic [2:0] status;
  logic [2:0] req_s1 = 3'b111;
  logic [2:0] req_s2 = 3'b111;
  int num_errors = 0;
  int cmp_count = 0;
  always #20 i_sys_clk = ~i_sys_clk;
  // request pins change on the device clock; the host synchronises them
  always @(posedge i_sys_clk) begin
    req_s1 <= {rx_service_req_n_n, tx_service_req_n_n, modem_service_req_n_n};
    req_s2 <= req_s1;
  end
  service_request_ack_chain uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_req_pending(pend), .i_modem_vector(vec[0]), .i_tx_vector(vec[1]),
    .i_rx_vector(vec[2]), .i_modem_match_reg(mat[0]), .i_tx_match_reg(mat[1]),
    .i_rx_match_reg(mat[2]), .i_chain_en(chain_en), .i_end_of_service_wr(eos_wr),
    .i_chain_ack_in_n(ack_in_n), .i_data_strobe_n(strobe_n), .i_addr(addr),
    .o_modem_service_req_n(modem_service_req_n_n), .o_tx_service_req_n(tx_service_req_n_n),
    .o_rx_service_req_n(rx_service_req_n_n), .o_request_status_reg(status),
    .o_chain_ack_out_n(ao_n), .o_transfer_ack_n(ta_n), .o_data(data), .o_data_oe_n(oe_n));
  host_ack_model host (.i_sys_clk(i_sys_clk), .i_transfer_ack_n(ta_n),
    .i_chain_ack_out_n(ao_n), .i_data(data), .i_data_oe_n(oe_n),
    .o_ack_in_n(ack_in_n), .o_strobe_n(strobe_n), .o_addr(addr));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_claim();
    chk("tx_req_n", {7'h00, tx_service_req_n_n}, 8'h00);
    for (int c = 0; c < 3; c++) begin
      host.ack_cycle(mat[c], t_ta, t_ao, t_d);
      chk("transfer_ack_n", {7'h00, t_ta}, 8'h00);
      chk("ack_out_n", {7'h00, t_ao}, 8'h01);
      chk("vector", t_d, vec[c]);
    end
    chk("req_n", {5'h00, rx_service_req_n_n, tx_service_req_n_n, modem_service_req_n_n}, 8'h07);
    chk("req_sync", {5'h00, req_s2}, 8'h07);
    $display("claim test done");
  endtask
  task automatic t_eos();
    eos_wr = 1'b1;
    @(posedge i_sys_clk);
    #1 eos_wr = 1'b0;
    repeat (2) begin
      @(posedge i_sys_clk);
      #1 chk("status", {5'h00, status}, 8'h00);
    end
    repeat (4) @(posedge i_sys_clk); // host pauses before rereading
    #1 chk("status", {5'h00, status}, 8'h07);
    chk("req_n", {5'h00, rx_service_req_n_n, tx_service_req_n_n, modem_service_req_n_n}, 8'h00);
    $display("end of service test done");
  endtask
  task automatic t_invalid();
    pend = 3'b000;
    repeat (4) @(posedge i_sys_clk);
    #1 host.ack_cycle(mat[1], t_ta, t_ao, t_d);
    chk("fwd ta_n ao_n", {6'h00, t_ta, t_ao}, 8'h02);
    host.ack_cycle(8'h84, t_ta, t_ao, t_d);
    chk("nomatch ta_n ao_n", {6'h00, t_ta, t_ao}, 8'h03);
    chk("nomatch data", t_d, 8'hff);
    chain_en = 1'b0;
    host.ack_cycle(mat[2], t_ta, t_ao, t_d);
    chk("nochain ta_n ao_n", {6'h00, t_ta, t_ao}, 8'h01);
    chk("nochain vector", t_d, 8'h00);
    $display("invalid acknowledge test done");
  endtask
  initial begin
    #(40 * 3000);
    num_errors++;
    $display("Error watchdog expected done seen hang");
    complete_run();
  end
  initial begin
    repeat (20) @(posedge i_sys_clk);
    #1 i_nrst = 1'b1;
    pend = 3'b111;
    repeat (4) @(posedge i_sys_clk);
    #1;
    t_claim();
    t_eos();
    t_invalid();
    complete_run();
  end
endmodule
